// ---- rtl/acq_pkg.sv ----
/*
  Constants and types shared by the input acquisition controller.
  Assumes a 10 MHz system clock derived from the host link clock.
*/
package acq_pkg;

  // ----------------------------------------
  // Clocking and sample rate limits
  // ----------------------------------------
  localparam int CLOCK_HZ = 10_000_000;
  localparam int MIN_RATE_HZ = 1_000;
  localparam int MAX_RATE_HZ = 216_000;
  // Fastest rate rounds the divisor up so 216 kHz is never exceeded
  localparam int MIN_DIV = (CLOCK_HZ + MAX_RATE_HZ - 1) / MAX_RATE_HZ;
  localparam int MAX_DIV = CLOCK_HZ / MIN_RATE_HZ;
  localparam int DIV_W = 14;

  // ----------------------------------------
  // Converter and channel layout
  // ----------------------------------------
  localparam int SETTLE_CONV = 63;
  localparam int SETTLE_W = 6;
  localparam int SAMPLE_W = 24;
  localparam int MAX_CH = 3;
  localparam int POST_W = 32;
  localparam int BUF_SCANS = 256;

  // ----------------------------------------
  // Reset values of per-channel settings and the shared gain
  // ----------------------------------------
  localparam logic EXCITE_RESET = 1'h0;
  localparam logic COUPLING_AC_RESET = 1'h0;
  localparam logic GAIN_TEN_RESET = 1'h0;

  // ----------------------------------------
  // Start trigger source encoding
  // ----------------------------------------
  localparam logic [2:0] SRC_SOFT = 3'h0;
  localparam logic [2:0] SRC_EXT_RISE = 3'h1;
  localparam logic [2:0] SRC_EXT_FALL = 3'h2;
  localparam logic [2:0] SRC_ANA_RISE = 3'h3;
  localparam logic [2:0] SRC_ANA_FALL = 3'h4;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SETTLE, ST_ARMED, ST_PRE, ST_POST, ST_DRAIN, ST_ONESHOT, ST_STOPPED
  } acq_state_t;

endpackage : acq_pkg

// ---- rtl/acq_control.sv ----
/*
  Input acquisition controller: sample pacing, settling discard, trigger
  sequencing, stops, single-value requests and per-channel sensor settings.
  Assumes all inputs are synchronous to clock and that the converters answer
  every convStart with exactly one adcValid carrying all lanes at once.
*/
// Notes on behaviour
// - Sample clock divisor is clamped to give 1 kHz to 216 kHz.
// - First 63 conversions after the clock starts are thrown away.
// - Capture starts with the very sample on which the start trigger lands.
// - Channel list length is limited to the fitted channels, from channel 0.
// - Start trigger begins pre-trigger capture of all listed lanes together.
// - Reference trigger during pre-trigger switches to post-trigger at once.
// - Post-trigger samples are counted; reaching the target ends the scan.
// - One conversion is requested per sample clock tick.
// - Orderly stop finishes the current buffer, then delivers it and halts.
// - Abrupt stop halts at once and hands back the partial buffer.
// - Once stopped, later triggers are ignored.
// - Each channel has an excitation enable, off after reset.
// - Each channel has AC or DC coupling, DC after reset.
// - Single-value request converts one channel once, no trigger.
// - All-channels request samples every lane together, returns an array.
// - Start source: software, external edge, or analog threshold either way.
// - Reference trigger is an analog threshold crossing either way.
// - Gain is selectable as 1 or 10.
// - External trigger fires on the programmed edge polarity.
// - As sync slave only the sync bus can start acquisition.
module acq_control
  import acq_pkg::*;
#(
  parameter int NCH = MAX_CH,
  parameter int BUF_LEN = BUF_SCANS
)(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [DIV_W-1:0] sampleDivisor,
  input wire logic [1:0] listLength,
  input wire logic [2:0] startSource,
  input wire logic [1:0] startChannel,
  input wire logic signed [SAMPLE_W-1:0] startLevel,
  input wire logic refRising,
  input wire logic [1:0] refChannel,
  input wire logic signed [SAMPLE_W-1:0] refLevel,
  input wire logic [POST_W-1:0] postTarget,
  input wire logic syncSlave,
  input wire logic syncTrigger,
  input wire logic extTrigger,
  input wire logic softTrigger,
  input wire logic scanStart,
  input wire logic stopOrderly,
  input wire logic stopAbrupt,
  input wire logic opSingle,
  input wire logic opAll,
  input wire logic [1:0] opChannel,
  input wire logic cfgWrite,
  input wire logic [NCH-1:0] excitationIn,
  input wire logic [NCH-1:0] couplingAcIn,
  input wire logic gainTenIn,
  input wire logic adcValid,
  input wire logic [NCH*SAMPLE_W-1:0] adcData,
  output logic convStart,
  output logic sampleValid,
  output logic [NCH*SAMPLE_W-1:0] sampleData,
  output logic bufferDone,
  output logic bufferPartial,
  output logic prePhase,
  output logic postPhase,
  output logic stopped,
  output logic singleValid,
  output logic [NCH*SAMPLE_W-1:0] singleData,
  output logic [NCH-1:0] sensor_excitation_conditioning,
  output logic [NCH-1:0] couplingAc,
  output logic gainTen
);

  localparam int DATA_W = NCH * SAMPLE_W;
  localparam int BUF_W = $clog2(BUF_LEN + 1);
  localparam logic [DIV_W-1:0] DIV_LO = DIV_W'(MIN_DIV);
  localparam logic [DIV_W-1:0] DIV_HI = DIV_W'(MAX_DIV);
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CONV - 1);
  localparam logic [BUF_W-1:0] BUF_LAST = BUF_W'(BUF_LEN - 1);

  typedef struct packed {
    acq_state_t state;
    logic [DIV_W-1:0] divCnt;
    logic [SETTLE_W-1:0] settleCnt;
    logic oneShot;
    logic allChan;
    logic [1:0] oneChan;
    logic pendTrig;
    logic extPrev;
    logic syncPrev;
    logic havePrev;
    logic [DATA_W-1:0] prevData;
    logic [POST_W-1:0] postCnt;
    logic [BUF_W-1:0] bufCnt;
    logic convStart;
    logic sampleValid;
    logic [DATA_W-1:0] sampleData;
    logic bufferDone;
    logic bufferPartial;
    logic singleValid;
    logic [DATA_W-1:0] singleData;
    logic [NCH-1:0] excite;
    logic [NCH-1:0] couplingAc;
    logic gainTen;
  } regs_t;

  regs_t r;
  regs_t next_r;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic signed [SAMPLE_W-1:0] lane(input logic [DATA_W-1:0] d,
                                                      input logic [1:0] ch);
    logic [1:0] c;
    c = (int'(ch) < NCH) ? ch : 2'h0;
    return d[int'(c)*SAMPLE_W +: SAMPLE_W];
  endfunction : lane

  // Level crossing between the previous and current valid sample
  function automatic logic crossed(input logic signed [SAMPLE_W-1:0] prev,
                                   input logic signed [SAMPLE_W-1:0] cur,
                                   input logic signed [SAMPLE_W-1:0] level,
                                   input logic rising);
    if (rising)
      return (prev < level) && (cur >= level);
    return (prev > level) && (cur <= level);
  endfunction : crossed

  // ----------------------------------------
  // Channel list mask and trigger detection
  // ----------------------------------------
  logic [1:0] listEff;
  logic [DATA_W-1:0] listMask;
  logic [DIV_W-1:0] divEff;
  logic extEdge;
  logic syncEdge;
  logic startEvt;
  logic anaStart;
  logic refCross;
  logic scanActive;
  logic capture;

  // Oversized list requests fall back to every fitted lane
  assign listEff = (listLength == 2'h0) ? 2'h1 :
                   (int'(listLength) > NCH) ? 2'(NCH) : listLength;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : g_lane
      assign listMask[g*SAMPLE_W +: SAMPLE_W] = {SAMPLE_W{(g < int'(listEff))}};
    end
  endgenerate

  // Out-of-range rates are clamped rather than refused
  assign divEff = (sampleDivisor < DIV_LO) ? DIV_LO :
                  (sampleDivisor > DIV_HI) ? DIV_HI : sampleDivisor;

  assign extEdge = (startSource == SRC_EXT_FALL) ? (!extTrigger && r.extPrev) :
                   (extTrigger && !r.extPrev);
  assign syncEdge = syncTrigger && !r.syncPrev;
  // A slave listens to the sync bus only
  assign startEvt = syncSlave ? syncEdge :
                    ((startSource == SRC_SOFT) && softTrigger) ||
                    (((startSource == SRC_EXT_RISE) || (startSource == SRC_EXT_FALL))
                     && extEdge);
  assign anaStart = !syncSlave && r.havePrev && adcValid &&
                    ((startSource == SRC_ANA_RISE) || (startSource == SRC_ANA_FALL)) &&
                    crossed(lane(r.prevData, startChannel), lane(adcData, startChannel),
                            startLevel, startSource == SRC_ANA_RISE);
  assign refCross = r.havePrev && adcValid &&
                    crossed(lane(r.prevData, refChannel), lane(adcData, refChannel),
                            refLevel, refRising);

  assign scanActive = ((r.state == ST_SETTLE) && !r.oneShot) || (r.state == ST_ARMED) ||
                      (r.state == ST_PRE) || (r.state == ST_POST) || (r.state == ST_DRAIN);
  assign capture = adcValid && !stopAbrupt &&
                   (((r.state == ST_ARMED) && (r.pendTrig || startEvt || anaStart)) ||
                    (r.state == ST_PRE) || (r.state == ST_POST) ||
                    (r.state == ST_DRAIN));

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic finish;
    finish = 1'b0;
    next_r = r;
    next_r.convStart = 1'b0;
    next_r.sampleValid = 1'b0;
    next_r.bufferDone = 1'b0;
    next_r.bufferPartial = 1'b0;
    next_r.singleValid = 1'b0;
    next_r.extPrev = extTrigger;
    next_r.syncPrev = syncTrigger;
    if (cfgWrite)
    begin
      next_r.excite = excitationIn;
      next_r.couplingAc = couplingAcIn;
      next_r.gainTen = gainTenIn;
    end
    // Sample clock runs only while converting; one request per tick
    if ((r.state != ST_IDLE) && (r.state != ST_STOPPED))
    begin
      if (r.divCnt == '0)
      begin
        next_r.divCnt = divEff - DIV_W'(1);
        next_r.convStart = 1'b1;
      end
      else
        next_r.divCnt = r.divCnt - DIV_W'(1);
    end
    else
      next_r.divCnt = '0;
    // Previous valid sample kept for threshold comparison
    if (adcValid && (r.state inside {ST_ARMED, ST_PRE, ST_POST, ST_DRAIN}))
    begin
      next_r.havePrev = 1'b1;
      next_r.prevData = adcData;
    end
    // Early software or edge triggers wait for the first valid sample
    if (((r.state == ST_SETTLE) && !r.oneShot) || (r.state == ST_ARMED))
      if (startEvt)
        next_r.pendTrig = 1'b1;
    case (r.state)
      ST_IDLE, ST_STOPPED:
      begin
        next_r.havePrev = 1'b0;
        next_r.pendTrig = 1'b0;
        next_r.settleCnt = '0;
        next_r.bufCnt = '0;
        // Triggers alone never leave here; only a new software request does
        if (scanStart)
        begin
          next_r.state = ST_SETTLE;
          next_r.oneShot = 1'b0;
        end
        else if (opSingle || opAll)
        begin
          next_r.state = ST_SETTLE;
          next_r.oneShot = 1'b1;
          next_r.allChan = opAll;
          next_r.oneChan = opChannel;
          next_r.gainTen = gainTenIn;
        end
      end
      ST_SETTLE:
        if (adcValid)
        begin
          if (r.settleCnt == SETTLE_LAST)
            next_r.state = r.oneShot ? ST_ONESHOT : ST_ARMED;
          else
            next_r.settleCnt = r.settleCnt + SETTLE_W'(1);
        end
      ST_ARMED:
        if (capture)
        begin
          next_r.state = ST_PRE;
          next_r.pendTrig = 1'b0;
        end
      ST_PRE:
        if (capture && refCross)
        begin
          next_r.state = ST_POST;
          next_r.postCnt = POST_W'(1);
          finish = (postTarget <= POST_W'(1));
        end
      ST_POST:
        if (capture)
        begin
          next_r.postCnt = r.postCnt + POST_W'(1);
          finish = (r.postCnt + POST_W'(1) >= postTarget);
        end
      ST_DRAIN:
        ;
      ST_ONESHOT:
        if (adcValid)
        begin
          next_r.singleValid = 1'b1;
          next_r.singleData = r.allChan ? adcData :
                              {{(DATA_W-SAMPLE_W){1'b0}}, lane(adcData, r.oneChan)};
          next_r.state = ST_IDLE;
        end
      default:
        next_r.state = ST_IDLE;
    endcase
    // Captured scans fill the buffer
    if (capture)
    begin
      next_r.sampleValid = 1'b1;
      next_r.sampleData = adcData & listMask;
      if (r.bufCnt == BUF_LAST)
      begin
        next_r.bufferDone = 1'b1;
        next_r.bufCnt = '0;
        if (r.state == ST_DRAIN)
          next_r.state = ST_STOPPED;
      end
      else
        next_r.bufCnt = r.bufCnt + BUF_W'(1);
    end
    // Scan end or abrupt stop hands back whatever is in the buffer
    if (finish || (scanActive && stopAbrupt))
    begin
      next_r.state = ST_STOPPED;
      if (next_r.bufCnt != '0)
      begin
        next_r.bufferDone = 1'b1;
        next_r.bufferPartial = 1'b1;
        next_r.bufCnt = '0;
      end
    end
    else if (scanActive && stopOrderly)
      next_r.state = (next_r.bufCnt == '0) ? ST_STOPPED : ST_DRAIN;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.state <= ST_IDLE;
      r.excite <= {NCH{EXCITE_RESET}};
      r.couplingAc <= {NCH{COUPLING_AC_RESET}};
      r.gainTen <= GAIN_TEN_RESET;
    end
    else
      r <= next_r;
  end

  // Outputs straight from the state register
  assign convStart = r.convStart;
  assign sampleValid = r.sampleValid;
  assign sampleData = r.sampleData;
  assign bufferDone = r.bufferDone;
  assign bufferPartial = r.bufferPartial;
  assign prePhase = (r.state == ST_PRE);
  assign postPhase = (r.state == ST_POST);
  assign stopped = (r.state == ST_STOPPED);
  assign singleValid = r.singleValid;
  assign singleData = r.singleData;
  assign sensor_excitation_conditioning = r.excite;
  assign couplingAc = r.couplingAc;
  assign gainTen = r.gainTen;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  logic [DIV_W:0] gapCnt;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      gapCnt <= '0;
    else if (r.convStart || (r.state == ST_IDLE) || (r.state == ST_STOPPED))
      gapCnt <= '0;
    else
      gapCnt <= gapCnt + (DIV_W+1)'(1);
  end

  a_rate_floor: assert property (r.convStart |=> !r.convStart [*8])
    else $error("sample ticks closer than the fastest rate");
  a_rate_ceiling: assert property (gapCnt <= (DIV_W+1)'(MAX_DIV))
    else $error("sample tick gap exceeds slowest rate");
  a_settle_discard: assert property ((r.state == ST_SETTLE) |=> !r.sampleValid && !r.singleValid)
    else $error("sample delivered during settling");
  a_start_align: assert property ((r.state == ST_ARMED) && capture |=>
                                  r.sampleValid && (r.state inside {ST_PRE, ST_STOPPED, ST_DRAIN})
                                  && (r.sampleData == ($past(adcData) & $past(listMask))))
    else $error("first capture not aligned with trigger sample");
  a_ref_switch: assert property ((r.state == ST_PRE) && capture && refCross && !stopOrderly
                                 && (postTarget > POST_W'(1)) |=> postPhase)
    else $error("reference trigger did not enter post phase");
  a_ref_early: assert property ((r.state == ST_ARMED) |=> !postPhase)
    else $error("reference trigger acted before start");
  a_post_stop: assert property (postPhase && capture && (r.postCnt + POST_W'(1) >= postTarget)
                                |=> stopped)
    else $error("scan did not end at post count");
  a_abrupt_stop: assert property (scanActive && stopAbrupt |=> stopped ##1 !r.sampleValid)
    else $error("abrupt stop kept sampling");
  a_stop_sticks: assert property (stopped && !scanStart && !opSingle && !opAll |=> stopped)
    else $error("trigger restarted a stopped scan");
  a_drain_end: assert property ((r.state == ST_DRAIN) && capture && (r.bufCnt == BUF_LAST)
                                |=> stopped && r.bufferDone && !r.bufferPartial)
    else $error("drain did not end on a full buffer");
  a_cfg_hold: assert property (!cfgWrite && (r.state != ST_IDLE) && (r.state != ST_STOPPED)
                               |=> $stable(r.excite) && $stable(r.couplingAc))
    else $error("channel settings changed without a write");
  a_oneshot_done: assert property ((r.state == ST_ONESHOT) && adcValid
                                   |=> singleValid ##1 (r.state != ST_ONESHOT))
    else $error("single request not answered");

  c_full_run: cover property (postPhase ##[1:1000] stopped);
  c_single: cover property (singleValid && !r.allChan);
  c_all: cover property (singleValid && r.allChan);
  c_abrupt: cover property (bufferPartial && stopped);

endmodule : acq_control

// ---- verif/adc_model.sv ----
/*
  Converter model: answers each convStart with one adcValid after a set
  latency, all lanes in one word. Assumes latency below the tick spacing.
*/
module adc_model
  import acq_pkg::*;
#(
  parameter int NCH = MAX_CH
)(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic convStart,
  input wire logic [7:0] latency,
  input wire logic [NCH*SAMPLE_W-1:0] lanes,
  output logic adcValid,
  output logic [NCH*SAMPLE_W-1:0] adcData
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] waitCnt;

  // ----------------------------------------
  // Result timing
  // ----------------------------------------
  // Data flips outside the pulse so a stale word never looks fresh
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      waitCnt <= 8'h00;
      adcValid <= 1'h0;
      adcData <= '0;
    end
    else
    begin
      adcValid <= (waitCnt == 8'h01);
      adcData <= (waitCnt == 8'h01) ? lanes : ~adcData;
      if (convStart)
        waitCnt <= latency;
      else if (waitCnt != 8'h00)
        waitCnt <= waitCnt - 8'h01;
    end
  end
endmodule : adc_model

// ---- verif/acq_control_bench.sv ----
/*
  Self-checking bench for the acquisition controller and converter model.
  Assumes a 100 ns clock, a four-scan buffer and three converter lanes.
*/
module acq_control_bench
  import acq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int BUF = 4;
  localparam int WATCH = 60000;
  localparam int P_SOFT = 0, P_SCAN = 1, P_ORD = 2, P_ABR = 3, P_ONE = 4, P_ALL = 5, P_CFG = 6;
  logic clock, rst_n, refRising, syncSlave, syncTrigger, extTrigger, gainTenIn;
  logic [DIV_W-1:0] sampleDivisor;
  logic [1:0] listLength, startChannel, refChannel, opChannel;
  logic [2:0] startSource, excitationIn, couplingAcIn, excite, couplingAc;
  logic signed [SAMPLE_W-1:0] startLevel, refLevel;
  logic [POST_W-1:0] postTarget;
  logic [6:0] pulses;
  logic softTrigger, scanStart, stopOrderly, stopAbrupt, opSingle, opAll, cfgWrite;
  logic [7:0] latency;
  logic [3*SAMPLE_W-1:0] lanes, adcData, sampleData, singleData;
  logic adcValid, convStart, sampleValid, bufferDone, bufferPartial;
  logic prePhase, postPhase, stopped, singleValid, gainTen;
  int failures, num_checks, conv, samp, cyc;

  // One-cycle host requests share one vector
  assign {cfgWrite, opAll, opSingle, stopAbrupt, stopOrderly, scanStart, softTrigger} = pulses;

  // ----------------------------------------
  // Design and converter
  // ----------------------------------------
  acq_control #(.NCH(3), .BUF_LEN(BUF)) i_acq_control (
    .clock(clock), .rst_n(rst_n), .sampleDivisor(sampleDivisor), .listLength(listLength),
    .startSource(startSource), .startChannel(startChannel), .startLevel(startLevel),
    .refRising(refRising), .refChannel(refChannel), .refLevel(refLevel),
    .postTarget(postTarget), .syncSlave(syncSlave), .syncTrigger(syncTrigger),
    .extTrigger(extTrigger), .softTrigger(softTrigger), .scanStart(scanStart),
    .stopOrderly(stopOrderly), .stopAbrupt(stopAbrupt), .opSingle(opSingle),
    .opAll(opAll), .opChannel(opChannel), .cfgWrite(cfgWrite),
    .excitationIn(excitationIn), .couplingAcIn(couplingAcIn), .gainTenIn(gainTenIn),
    .adcValid(adcValid), .adcData(adcData), .convStart(convStart),
    .sampleValid(sampleValid), .sampleData(sampleData), .bufferDone(bufferDone),
    .bufferPartial(bufferPartial), .prePhase(prePhase), .postPhase(postPhase),
    .stopped(stopped), .singleValid(singleValid), .singleData(singleData),
    .sensor_excitation_conditioning(excite), .couplingAc(couplingAc), .gainTen(gainTen)
  );
  adc_model #(.NCH(3)) i_adc_model (
    .clock(clock), .rst_n(rst_n), .convStart(convStart), .latency(latency),
    .lanes(lanes), .adcValid(adcValid), .adcData(adcData)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input bit ok, input string msg);
    num_checks++;
    if (!ok)
    begin
      failures++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : check

  task automatic report_and_stop();
    if (failures == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  // Raises one request for exactly one sampling edge
  task automatic pulse(input int k);
    @(posedge clock);
    #1 pulses = 7'h01 << k;
    @(posedge clock);
    #1 pulses = 7'h00;
  endtask : pulse

  function automatic bit hit(input int w);
    case (w)
      0: return sampleValid === 1'h1;
      1: return postPhase === 1'h1;
      2: return stopped === 1'h1;
      3: return singleValid === 1'h1;
      4: return convStart === 1'h1;
      default: return 1'h0;
    endcase
  endfunction : hit

  // Steps cycles, tallying results; a negative selector just waits
  task automatic run_until(input int w, input int maxc);
    cyc = 0;
    repeat (maxc)
    begin
      @(posedge clock);
      #2;
      cyc++;
      conv += (adcValid === 1'h1);
      samp += (sampleValid === 1'h1);
      if (hit(w))
        return;
    end
    if (w >= 0)
      check(1'h0, "timeout waiting for output");
  endtask : run_until

  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial
  begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end

  // Bound is well above the slowest scan sequence below
  initial
  begin
    #(WATCH * 100);
    check(1'h0, "watchdog expired");
    report_and_stop();
  end

  initial
  begin
    {failures, num_checks, conv, samp} = '0;
    pulses = 7'h00;
    rst_n = 1'h0;
    sampleDivisor = 14'h0005;
    listLength = 2'h2;
    startSource = SRC_SOFT;
    startChannel = 2'h0;
    startLevel = 24'h000000;
    refRising = 1'h1;
    refChannel = 2'h0;
    refLevel = 24'h000064;
    postTarget = 32'h00000003;
    {syncSlave, syncTrigger, extTrigger, gainTenIn} = 4'h3;
    opChannel = 2'h2;
    excitationIn = 3'h5;
    couplingAcIn = 3'h6;
    latency = 8'h02;
    lanes = {24'h000033, 24'h000022, 24'h000010};
    repeat (3) @(posedge clock);
    #1 rst_n = 1'h1;
    check(excite === 3'h0 && couplingAc === 3'h0 && gainTen === 1'h0, "reset");
    pulse(P_CFG);
    check(excite === 3'h5 && couplingAc === 3'h6 && gainTen === 1'h1, "config");
    // Single and all-lane values, each after the settling discard
    gainTenIn = 1'h0;
    pulse(P_ONE);
    run_until(3, 4000);
    check(conv == 64 && singleData === {48'h0, 24'h000033}, "single value");
    check(gainTen === 1'h0, "gain reload");
    conv = 0;
    pulse(P_ALL);
    run_until(3, 4000);
    check(conv == 64 && singleData === lanes, "all lanes");
    // Soft start during settling, reference crossing, post count
    conv = 0;
    pulse(P_SCAN);
    pulse(P_SOFT);
    run_until(4, 100);
    run_until(4, 100);
    check(cyc == 47, "clamped tick spacing");
    run_until(0, 4000);
    check(conv == 64 && prePhase === 1'h1, "first valid sample");
    check(sampleData === {24'h0, 24'h000022, 24'h000010}, "listed lanes");
    lanes[23:0] = 24'h0000C8;
    run_until(1, 200);
    check(sampleValid === 1'h1 && prePhase === 1'h0, "reference switch");
    samp = 0;
    run_until(2, 400);
    check(samp == 2 && bufferDone === 1'h1 && bufferPartial === 1'h0, "post count");
    samp = 0;
    pulse(P_SOFT);
    extTrigger = 1'h0;
    run_until(-1, 300);
    check(samp == 0 && stopped === 1'h1, "late triggers");
    // External falling start with a slow converter, then abrupt stop
    extTrigger = 1'h1;
    startSource = SRC_EXT_FALL;
    latency = 8'h1E;
    conv = 0;
    pulse(P_SCAN);
    extTrigger = 1'h0;
    run_until(0, 4000);
    check(conv == 64, "external falling start");
    run_until(0, 200);
    pulse(P_ABR);
    check(stopped === 1'h1 && bufferDone === 1'h1 && bufferPartial === 1'h1, "abrupt");
    samp = 0;
    run_until(-1, 200);
    check(samp == 0, "no capture after abrupt stop");
    // Slower divisor and orderly stop draining to a full buffer
    sampleDivisor = 14'h00C8;
    startSource = SRC_SOFT;
    latency = 8'h02;
    pulse(P_SCAN);
    pulse(P_SOFT);
    run_until(4, 300);
    run_until(4, 300);
    check(cyc == 200, "tick spacing");
    run_until(0, 20000);
    samp = 0;
    pulse(P_ORD);
    run_until(2, 2000);
    check(samp == 3 && bufferDone === 1'h1 && bufferPartial === 1'h0, "orderly");
    // Analog rising start on lane 1 waits for a real crossing
    sampleDivisor = 14'h002F;
    startSource = SRC_ANA_RISE;
    startChannel = 2'h1;
    startLevel = 24'h000030;
    pulse(P_SCAN);
    samp = 0;
    run_until(-1, 3200);
    check(samp == 0 && prePhase === 1'h0, "analog start waits");
    lanes[47:24] = 24'h000040;
    run_until(0, 200);
    check(prePhase === 1'h1 && sampleData[47:24] === 24'h000040, "analog start");
    pulse(P_ABR);
    // Slave mode takes its start from the sync line only
    syncSlave = 1'h1;
    pulse(P_SCAN);
    pulse(P_SOFT);
    samp = 0;
    run_until(-1, 3500);
    check(samp == 0, "slave ignores local start");
    syncTrigger = 1'h1;
    run_until(0, 200);
    check(prePhase === 1'h1, "sync start");
    pulse(P_ABR);
    report_and_stop();
  end
endmodule : acq_control_bench
